// [fpebtp_top.sv]
// Floating-point error / pending break multiplexer and forced thermal throttle logic.
// Operation
// - Without stop-clock request, output shows unmasked floating-point error.
// - With stop-clock request, output shows only a pending break event.
// - Asserted force-throttle input turns on thermal control in both cores.
// - Thermal control stays on until force-throttle input is released.
`timescale 1ns/1ps
`include "fpebtp_defines.svh"

module fpebtp_top #(
  parameter int CORES = `FPEBTP_CORES
) (
  input  wire logic             CLK_I,
  input  wire logic             SRST_I,
  input  wire logic             STOP_CLOCK_REQUEST_N_I,
  input  wire logic             FORCE_THERMAL_THROTTLE_N_I,
  input  wire logic [CORES-1:0] FPU_ERROR_UNMASKED_I,
  input  wire logic [CORES-1:0] BREAK_PENDING_I,
  output logic                  FPU_ERROR_BREAK_PENDING_N_O,
  output logic      [CORES-1:0] THERMAL_CONTROL_ACTIVE_O,
  output logic      [1:0]       MODE_O
);

  // ----------------------------------------------------------------
  // Input synchronisation.
  // ----------------------------------------------------------------
  logic stop_n_s;
  logic force_n_s;

  fpebtp_sync u_sync_stop (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .pin_n_i (STOP_CLOCK_REQUEST_N_I),
    .pin_n_o (stop_n_s)
  );

  fpebtp_sync u_sync_force (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .pin_n_i (FORCE_THERMAL_THROTTLE_N_I),
    .pin_n_o (force_n_s)
  );

  function automatic logic any_set(input logic [CORES-1:0] v);
    any_set = |v;
  endfunction : any_set

  // ----------------------------------------------------------------
  // Stop-clock mode tracking.
  // ----------------------------------------------------------------
  fpebtp_pkg::fpebtp_mode_t mode_q;
  fpebtp_pkg::fpebtp_mode_t mode_d;

  always_comb begin
    case (mode_q)
      fpebtp_pkg::FPEBTP_ST_RUN:
        mode_d = !stop_n_s ? fpebtp_pkg::FPEBTP_ST_STOPPING : fpebtp_pkg::FPEBTP_ST_RUN;
      fpebtp_pkg::FPEBTP_ST_STOPPING:
        mode_d = !stop_n_s ? fpebtp_pkg::FPEBTP_ST_STOPPED : fpebtp_pkg::FPEBTP_ST_RUN;
      fpebtp_pkg::FPEBTP_ST_STOPPED:
        mode_d = !stop_n_s ? fpebtp_pkg::FPEBTP_ST_STOPPED : fpebtp_pkg::FPEBTP_ST_RUN;
      default:
        mode_d = fpebtp_pkg::FPEBTP_ST_RUN;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_q <= fpebtp_pkg::FPEBTP_ST_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      MODE_O <= 2'h0;
    end else begin
      MODE_O <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Multiplexed error / pending break output.
  // ----------------------------------------------------------------
  logic err_brk_pend_d;

  always_comb begin
    if (stop_n_s) begin
      err_brk_pend_d = !any_set(FPU_ERROR_UNMASKED_I);
    end else begin
      err_brk_pend_d = !any_set(BREAK_PENDING_I);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      FPU_ERROR_BREAK_PENDING_N_O <= `FPEBTP_PIN_IDLE;
    end else begin
      FPU_ERROR_BREAK_PENDING_N_O <= err_brk_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Forced thermal throttle of every core.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      THERMAL_CONTROL_ACTIVE_O <= '0;
    end else begin
      THERMAL_CONTROL_ACTIVE_O <= {CORES{!force_n_s}};
    end
  end

  // ----------------------------------------------------------------
  // Assertions on the throttle path.
  // ----------------------------------------------------------------
  sequence s_force_pin_low3;
    !FORCE_THERMAL_THROTTLE_N_I [*3];
  endsequence

  sequence s_force_pin_high3;
    FORCE_THERMAL_THROTTLE_N_I [*3];
  endsequence

  sequence s_force_seen;
    !force_n_s;
  endsequence

  property p_force_all_cores;
    @(posedge CLK_I) disable iff (SRST_I)
      s_force_seen |=> (THERMAL_CONTROL_ACTIVE_O == {CORES{1'b1}});
  endproperty
  a_force_all_cores: assert property (p_force_all_cores) else $error("Throttle not active in all cores.");

  property p_force_held;
    @(posedge CLK_I) disable iff (SRST_I)
      (!force_n_s && $past(!force_n_s)) |=> THERMAL_CONTROL_ACTIVE_O[0];
  endproperty
  a_force_held: assert property (p_force_held) else $error("Throttle dropped while forced.");

  property p_force_release;
    @(posedge CLK_I) disable iff (SRST_I)
      force_n_s |=> (THERMAL_CONTROL_ACTIVE_O == '0);
  endproperty
  a_force_release: assert property (p_force_release) else $error("Throttle active without force.");

  property p_pin_latency;
    @(posedge CLK_I) disable iff (SRST_I)
      s_force_pin_low3 |=> THERMAL_CONTROL_ACTIVE_O[0];
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("Force pin latency exceeded.");

  property p_pin_release;
    @(posedge CLK_I) disable iff (SRST_I)
      s_force_pin_high3 |=> (THERMAL_CONTROL_ACTIVE_O == '0);
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("Throttle not released after pin rose.");

  property p_throttle_uniform;
    @(posedge CLK_I) disable iff (SRST_I)
      (THERMAL_CONTROL_ACTIVE_O == '0) || (THERMAL_CONTROL_ACTIVE_O == {CORES{1'b1}});
  endproperty
  a_throttle_uniform: assert property (p_throttle_uniform) else $error("Cores disagree on throttle state.");

  // ----------------------------------------------------------------
  // Assertions on the multiplexed pin and the stop-clock mode.
  // ----------------------------------------------------------------
  sequence s_stop_seen;
    !stop_n_s;
  endsequence

  sequence s_stop_pin_low3;
    !STOP_CLOCK_REQUEST_N_I [*3];
  endsequence

  sequence s_stop_pin_high3;
    STOP_CLOCK_REQUEST_N_I [*3];
  endsequence

  property p_err_run;
    @(posedge CLK_I) disable iff (SRST_I)
      (stop_n_s && any_set(FPU_ERROR_UNMASKED_I)) |=> !FPU_ERROR_BREAK_PENDING_N_O;
  endproperty
  a_err_run: assert property (p_err_run) else $error("Floating-point error not reported.");

  property p_err_quiet;
    @(posedge CLK_I) disable iff (SRST_I)
      (stop_n_s && !any_set(FPU_ERROR_UNMASKED_I)) |=> FPU_ERROR_BREAK_PENDING_N_O;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("Spurious error indication.");

  property p_brk_stop;
    @(posedge CLK_I) disable iff (SRST_I)
      !stop_n_s |=> (FPU_ERROR_BREAK_PENDING_N_O == !$past(any_set(BREAK_PENDING_I)));
  endproperty
  a_brk_stop: assert property (p_brk_stop) else $error("Pending break indication wrong.");

  property p_mode_stopped;
    @(posedge CLK_I) disable iff (SRST_I)
      (s_stop_seen ##1 s_stop_seen) |-> (mode_q != fpebtp_pkg::FPEBTP_ST_RUN);
  endproperty
  a_mode_stopped: assert property (p_mode_stopped) else $error("Mode missed stop-clock request.");

  property p_err_masked_stop;
    @(posedge CLK_I) disable iff (SRST_I)
      (!stop_n_s && !any_set(BREAK_PENDING_I)) |=> FPU_ERROR_BREAK_PENDING_N_O;
  endproperty
  a_err_masked_stop: assert property (p_err_masked_stop) else $error("Error shown during stop-clock.");

  property p_mode_run;
    @(posedge CLK_I) disable iff (SRST_I)
      stop_n_s |=> (mode_q == fpebtp_pkg::FPEBTP_ST_RUN);
  endproperty
  a_mode_run: assert property (p_mode_run) else $error("Mode left run without stop-clock.");

  property p_stop_pin_latency;
    @(posedge CLK_I) disable iff (SRST_I)
      s_stop_pin_low3 |=> (MODE_O != fpebtp_pkg::FPEBTP_ST_RUN);
  endproperty
  a_stop_pin_latency: assert property (p_stop_pin_latency) else $error("Mode missed stop-clock pin.");

  property p_stop_pin_release;
    @(posedge CLK_I) disable iff (SRST_I)
      s_stop_pin_high3 |=> (MODE_O == fpebtp_pkg::FPEBTP_ST_RUN);
  endproperty
  a_stop_pin_release: assert property (p_stop_pin_release) else $error("Mode stuck after pin rose.");

endmodule : fpebtp_top

// [fpebtp_defines.svh]
// Timing counts, reset values and widths for the sideband pin logic.
`ifndef FPEBTP_DEFINES_SVH
`define FPEBTP_DEFINES_SVH

`define FPEBTP_CORES          2
`define FPEBTP_SYNC_STAGES    2
`define FPEBTP_PIN_IDLE       1'h1
`define FPEBTP_THROTTLE_OFF   2'h0
`define FPEBTP_PIPE_LATENCY   3

`endif

// [fpebtp_pkg.sv]
// Types shared by the sideband pin logic.
package fpebtp_pkg;

  typedef enum logic [1:0] {
    FPEBTP_ST_RUN      = 2'h0,
    FPEBTP_ST_STOPPING = 2'h1,
    FPEBTP_ST_STOPPED  = 2'h3
  } fpebtp_mode_t;

endpackage : fpebtp_pkg

// [fpebtp_sync.sv]
// Two-stage synchroniser for an active-low pin, resetting to the idle level.
`timescale 1ns/1ps
`include "fpebtp_defines.svh"

module fpebtp_sync (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic pin_n_i,
  output logic      pin_n_o
);

  logic meta_q;
  logic stable_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q   <= `FPEBTP_PIN_IDLE;
      stable_q <= `FPEBTP_PIN_IDLE;
    end else begin
      meta_q   <= pin_n_i;
      stable_q <= meta_q;
    end
  end

  assign pin_n_o = stable_q;

endmodule : fpebtp_sync

// [fpebtp_platform.sv]
// Platform model that drives the stop-clock and force-throttle pins.
`timescale 1ns/1ps

module fpebtp_platform (
  input  wire logic clk_i,
  input  wire logic stop_req_i,
  input  wire logic force_req_i,
  input  wire logic wake_en_i,
  input  wire logic pending_n_i,
  output logic      stop_n_o,
  output logic      force_n_o
);
  logic woken_q;

  // A pending break during a stop request wakes the processor.
  always_ff @(posedge clk_i) begin
    woken_q <= stop_req_i & wake_en_i & (woken_q | ~pending_n_i);
  end

  assign stop_n_o  = ~stop_req_i | woken_q;
  assign force_n_o = ~force_req_i;
endmodule : fpebtp_platform

// [tb_top.sv]
// Self-checking bench for the sideband pin logic.
`timescale 1ns/1ps
`include "fpebtp_defines.svh"

module tb_top;
  logic       clk, srst, stop_req, force_req, wake_en, stop_n, force_n, pend_n;
  logic [1:0] err, brk, tca, mode;
  int         err_total = 0;
  int         tests_run = 0;
  int         seed      = 32'hf1f3;

  fpebtp_top #(.CORES(`FPEBTP_CORES)) fpebtp_top_i (
    .CLK_I                       (clk),
    .SRST_I                      (srst),
    .STOP_CLOCK_REQUEST_N_I      (stop_n),
    .FORCE_THERMAL_THROTTLE_N_I  (force_n),
    .FPU_ERROR_UNMASKED_I        (err),
    .BREAK_PENDING_I             (brk),
    .FPU_ERROR_BREAK_PENDING_N_O (pend_n),
    .THERMAL_CONTROL_ACTIVE_O    (tca),
    .MODE_O                      (mode)
  );

  fpebtp_platform fpebtp_platform_i (
    .clk_i       (clk),
    .stop_req_i  (stop_req),
    .force_req_i (force_req),
    .wake_en_i   (wake_en),
    .pending_n_i (pend_n),
    .stop_n_o    (stop_n),
    .force_n_o   (force_n)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  function automatic logic exp_pin(input logic stop, input logic [1:0] e, input logic [1:0] b);
    return stop ? ~|b : ~|e;
  endfunction : exp_pin

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #500000;
    err_total++;
    stop_test();
  end

  initial begin
    {srst, stop_req, force_req, wake_en, err, brk} = 8'h80;
    repeat (3) @(posedge clk);
    #1;
    srst = 1'h0;
    check({3'h0, pend_n, tca, mode}, 8'h10);
    for (int i = 0; i < 300; i++) begin
      {stop_req, force_req, err, brk} = 6'($random(seed));
      if (i < 2) {stop_req, force_req, err, brk} = (i == 0) ? 6'h2C : 6'h13;
      repeat (`FPEBTP_PIPE_LATENCY) @(posedge clk);
      #1;
      check({6'h00, tca}, force_req ? 8'h03 : 8'h00);
      @(posedge clk);
      #1;
      check({7'h00, pend_n}, {7'h00, exp_pin(stop_req, err, brk)});
      check({6'h00, tca}, force_req ? 8'h03 : 8'h00);
      check({6'h00, mode}, {6'h00, stop_req, stop_req});
    end
    {stop_req, force_req, wake_en, err, brk} = 7'h56;
    repeat (12) @(posedge clk);
    #1;
    check({7'h00, pend_n}, 8'h00);
    check({6'h00, mode}, 8'h00);
    stop_test();
  end
endmodule : tb_top
